// file: verilog/flash_ctl_map.vh
`ifndef FLASH_CTL_MAP_VH
`define FLASH_CTL_MAP_VH
// Controller register offsets (software port, one address per 32-bit register)
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_WDATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
// Control register fields
`define CTRL_GO_BIT 0
`define CTRL_CMD_LSB 1
`define CTRL_CMD_W 3
// Commands accepted from software
`define CMD_ERASE 3'h0
`define CMD_ADD_SECTOR 3'h1
`define CMD_SUSPEND 3'h2
`define CMD_RESUME 3'h3
`define CMD_QUERY 3'h4
`define CMD_RESET 3'h5
`define CMD_READ 3'h6
`define CMD_WRITE 3'h7
// Flash addresses and command codes
`define FA_UNLOCK1 19'h00555
`define FA_UNLOCK2 19'h002aa
`define FA_QUERY 19'h00055
`define FD_UNLOCK1 8'haa
`define FD_UNLOCK2 8'h55
`define FD_SETUP 8'h80
`define FD_ERASE 8'h30
`define FD_SUSPEND 8'hb0
`define FD_RESUME 8'h30
`define FD_QUERY 8'h98
`define FD_RESET 8'hf0
// Status bit positions in a flash read
`define DQ_POLL 7
`define DQ_TOGGLE 6
`define DQ_ERR 5
`define DQ_WINDOW 3
`define DQ_TOGGLE2 2
// Timing: bus phase length and resume guard
`define CLK_MHZ 10
`define PHASE_CYC 4'h2
`define RESUME_GAP_US 400
`define RESUME_GAP_CYC 13'h0fa0
`define SUSPEND_LIMIT_US 20
`define SUSPEND_POLL_CYC (`SUSPEND_LIMIT_US * `CLK_MHZ)
`define LOOP_LIMIT 11'h400
`endif

// file: verilog/bus_cycle.v
`include "flash_ctl_map.vh"
// One flash bus cycle: write (we low) or read (oe low), timed by phase counter
module bus_cycle (
  input wire ref_clk,
  input wire rst_b,
  input wire start,
  input wire is_write,
  input wire [18:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] dq_sync,
  output reg done_ff,
  output reg [7:0] rdata_ff,
  output reg [18:0] addr_ff,
  output reg [7:0] dq_out_ff,
  output reg dq_oe_ff,
  output reg ce_b_ff,
  output reg we_b_ff,
  output reg oe_b_ff
);
  localparam S_IDLE = 3'b001;
  localparam S_ACT = 3'b010;
  localparam S_END = 3'b100;
  reg [2:0] st_ff;
  reg [3:0] cnt_ff;
  reg wr_ff;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      st_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 8'h00;
      addr_ff <= 19'h00000;
      dq_out_ff <= 8'h00;
      dq_oe_ff <= 1'b0;
      ce_b_ff <= 1'b1;
      we_b_ff <= 1'b1;
      oe_b_ff <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (start) begin
            wr_ff <= is_write;
            addr_ff <= addr;
            dq_out_ff <= wdata;
            dq_oe_ff <= is_write;
            ce_b_ff <= 1'b0;
            we_b_ff <= ~is_write;
            oe_b_ff <= is_write;
            cnt_ff <= `PHASE_CYC;
            st_ff <= S_ACT;
          end
        end
        S_ACT: begin
          if (cnt_ff == 4'h0) begin
            we_b_ff <= 1'b1;
            oe_b_ff <= 1'b1;
            ce_b_ff <= 1'b1;
            if (!wr_ff) rdata_ff <= dq_sync;
            st_ff <= S_END;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        S_END: begin
          dq_oe_ff <= 1'b0;
          done_ff <= 1'b1;
          st_ff <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// file: verilog/flash_erase_ctl.v
// The implementer's own choices: the address-and-strobe port and the register addresses.
`include "flash_ctl_map.vh"
module flash_erase_ctl (
  input wire ref_clk,
  input wire rst_b,
  input wire [3:0] sw_addr,
  input wire [31:0] sw_wdata,
  input wire sw_wr,
  input wire sw_rd,
  output reg [31:0] sw_rdata_ff,
  input wire [7:0] dq_in,
  input wire ready_busy_output,
  output wire [7:0] dq_out,
  output wire dq_oe,
  output wire [18:0] fl_addr,
  output wire ce_b,
  output wire we_b,
  output wire oe_b
);
  localparam M_READ = 5'b00001;
  localparam M_WINDOW = 5'b00010;
  localparam M_ERASE = 5'b00100;
  localparam M_SUSP = 5'b01000;
  localparam M_QUERY = 5'b10000;
  reg [7:0] dq_s1_ff, dq_s2_ff;
  reg rb_s1_ff, rb_s2_ff;
  reg [18:0] addr_reg_ff;
  reg [7:0] wdata_reg_ff;
  reg [7:0] rdata_reg_ff;
  reg [4:0] mode_ff;
  reg [4:0] prev_mode_ff;
  reg [18:0] seq_a_ff [0:5];
  reg [7:0] seq_d_ff [0:5];
  reg [2:0] seq_len_ff;
  reg [2:0] seq_idx_ff;
  reg busy_ff;
  reg start_ff;
  reg is_wr_ff;
  reg refused_ff;
  reg [2:0] cmd_ff;
  reg [12:0] gap_ff;
  reg [10:0] loops_ff;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  wire [2:0] sw_cmd = sw_wdata[`CTRL_CMD_LSB +: `CTRL_CMD_W];
  wire go = sw_wr && sw_addr == `REG_CTRL && sw_wdata[`CTRL_GO_BIT] && !busy_ff;
  integer i;
  bus_cycle u_cycle (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(start_ff),
    .is_write(is_wr_ff),
    .addr(seq_a_ff[0]),
    .wdata(seq_d_ff[0]),
    .dq_sync(dq_s2_ff),
    .done_ff(cyc_done),
    .rdata_ff(cyc_rdata),
    .addr_ff(fl_addr),
    .dq_out_ff(dq_out),
    .dq_oe_ff(dq_oe),
    .ce_b_ff(ce_b),
    .we_b_ff(we_b),
    .oe_b_ff(oe_b)
  );
  // Command allowed in the present mode
  reg allow;
  always @* begin
    allow = 1'b0;
    case (cmd_ff)
      `CMD_ERASE: allow = mode_ff == M_READ;
      `CMD_ADD_SECTOR: allow = mode_ff == M_WINDOW;
      `CMD_SUSPEND: allow = (mode_ff == M_WINDOW) || (mode_ff == M_ERASE && gap_ff == 13'h0000);
      `CMD_RESUME: allow = mode_ff == M_SUSP;
      `CMD_QUERY: allow = mode_ff == M_READ || mode_ff == M_SUSP;
      `CMD_RESET: allow = mode_ff != M_ERASE;
      `CMD_READ: allow = 1'b1;
      `CMD_WRITE: allow = mode_ff == M_READ || mode_ff == M_SUSP;
      default: allow = 1'b0;
    endcase
  end
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
      rb_s1_ff <= 1'b1;
      rb_s2_ff <= 1'b1;
      addr_reg_ff <= 19'h00000;
      wdata_reg_ff <= 8'h00;
      rdata_reg_ff <= 8'h00;
      mode_ff <= M_READ;
      prev_mode_ff <= M_READ;
      seq_len_ff <= 3'h0;
      seq_idx_ff <= 3'h0;
      busy_ff <= 1'b0;
      start_ff <= 1'b0;
      is_wr_ff <= 1'b0;
      refused_ff <= 1'b0;
      cmd_ff <= 3'h0;
      gap_ff <= 13'h0000;
      loops_ff <= 11'h000;
      sw_rdata_ff <= 32'h00000000;
      for (i = 0; i < 6; i = i + 1) begin
        seq_a_ff[i] <= 19'h00000;
        seq_d_ff[i] <= 8'h00;
      end
    end else begin
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
      rb_s1_ff <= ready_busy_output;
      rb_s2_ff <= rb_s1_ff;
      start_ff <= 1'b0;
      if (gap_ff != 13'h0000) gap_ff <= gap_ff - 13'h0001;
      if (sw_wr && sw_addr == `REG_ADDR) addr_reg_ff <= sw_wdata[18:0];
      if (sw_wr && sw_addr == `REG_WDATA) wdata_reg_ff <= sw_wdata[7:0];
      if (go) begin
        cmd_ff <= sw_cmd;
        busy_ff <= 1'b1;
        seq_idx_ff <= 3'h0;
        is_wr_ff <= 1'b1;
        seq_len_ff <= 3'h1;
        seq_a_ff[0] <= addr_reg_ff;
        seq_d_ff[0] <= `FD_SUSPEND;
        case (sw_cmd)
          `CMD_ERASE: begin
            seq_len_ff <= 3'h6;
            seq_a_ff[0] <= `FA_UNLOCK1;
            seq_d_ff[0] <= `FD_UNLOCK1;
            seq_a_ff[1] <= `FA_UNLOCK2;
            seq_d_ff[1] <= `FD_UNLOCK2;
            seq_a_ff[2] <= `FA_UNLOCK1;
            seq_d_ff[2] <= `FD_SETUP;
            seq_a_ff[3] <= `FA_UNLOCK1;
            seq_d_ff[3] <= `FD_UNLOCK1;
            seq_a_ff[4] <= `FA_UNLOCK2;
            seq_d_ff[4] <= `FD_UNLOCK2;
            seq_a_ff[5] <= addr_reg_ff;
            seq_d_ff[5] <= `FD_ERASE;
          end
          `CMD_ADD_SECTOR: seq_d_ff[0] <= `FD_ERASE;
          `CMD_RESUME: seq_d_ff[0] <= `FD_RESUME;
          `CMD_QUERY: begin
            seq_a_ff[0] <= `FA_QUERY;
            seq_d_ff[0] <= `FD_QUERY;
          end
          `CMD_RESET: seq_d_ff[0] <= `FD_RESET;
          `CMD_READ: is_wr_ff <= 1'b0;
          `CMD_WRITE: seq_d_ff[0] <= wdata_reg_ff;
          default: seq_d_ff[0] <= `FD_SUSPEND;
        endcase
      end else if (busy_ff && seq_idx_ff == 3'h0 && seq_len_ff != 3'h0 && !start_ff
                   && !refused_ff) begin
        if (!allow && seq_idx_ff == 3'h0) begin
          refused_ff <= 1'b1;
          busy_ff <= 1'b0;
          seq_len_ff <= 3'h0;
        end else begin
          start_ff <= 1'b1;
          seq_len_ff <= seq_len_ff - 3'h1;
          seq_idx_ff <= 3'h7;
        end
      end else if (busy_ff && seq_idx_ff == 3'h6) begin
        // Suspend counts as done only once the device reports ready
        if (rb_s2_ff) begin
          busy_ff <= 1'b0;
          seq_idx_ff <= 3'h0;
        end
      end else if (busy_ff && cyc_done) begin
        if (!is_wr_ff) rdata_reg_ff <= cyc_rdata;
        if (seq_len_ff != 3'h0) begin
          seq_idx_ff <= 3'h0;
          start_ff <= 1'b0;
          seq_a_ff[0] <= seq_a_ff[1];
          seq_d_ff[0] <= seq_d_ff[1];
          for (i = 1; i < 5; i = i + 1) begin
            seq_a_ff[i] <= seq_a_ff[i + 1];
            seq_d_ff[i] <= seq_d_ff[i + 1];
          end
        end else begin
          busy_ff <= 1'b0;
          seq_idx_ff <= 3'h0;
          case (cmd_ff)
            `CMD_ERASE: mode_ff <= M_WINDOW;
            `CMD_SUSPEND: begin
              mode_ff <= M_SUSP;
              busy_ff <= 1'b1;
              seq_idx_ff <= 3'h6;
            end
            `CMD_RESUME: begin
              mode_ff <= M_ERASE;
              gap_ff <= `RESUME_GAP_CYC;
              if (loops_ff != `LOOP_LIMIT) loops_ff <= loops_ff + 11'h001;
            end
            `CMD_QUERY: begin
              prev_mode_ff <= mode_ff;
              mode_ff <= M_QUERY;
            end
            `CMD_RESET: mode_ff <= (mode_ff == M_QUERY) ? prev_mode_ff : M_READ;
            `CMD_WRITE: if (mode_ff == M_WINDOW) mode_ff <= M_READ;
            default: mode_ff <= mode_ff;
          endcase
        end
      end
      if (go) refused_ff <= 1'b0;
      // Track device progress from status bits
      if (!busy_ff && !is_wr_ff && (mode_ff == M_WINDOW || mode_ff == M_ERASE)) begin
        if (rdata_reg_ff[`DQ_WINDOW]) mode_ff <= M_ERASE;
        if (rdata_reg_ff[`DQ_POLL] && rb_s2_ff) mode_ff <= M_READ;
      end
      if (sw_rd) begin
        case (sw_addr)
          `REG_ADDR: sw_rdata_ff <= {13'h0000, addr_reg_ff};
          `REG_WDATA: sw_rdata_ff <= {24'h000000, wdata_reg_ff};
          `REG_STATUS: sw_rdata_ff <= {6'h00, mode_ff, loops_ff == `LOOP_LIMIT, loops_ff[7:0],
                                      rdata_reg_ff[`DQ_ERR], rdata_reg_ff[`DQ_POLL],
                                      rb_s2_ff, refused_ff, 4'h0, gap_ff != 13'h0000,
                                      busy_ff, 2'h0};
          `REG_RDATA: sw_rdata_ff <= {24'h000000, rdata_reg_ff};
          default: sw_rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// file: dv/flash_erase_ctl_asserts.sv
module flash_erase_ctl_asserts (
  input wire ref_clk,
  input wire rst_b,
  input wire ce_b,
  input wire we_b,
  input wire oe_b,
  input wire dq_oe,
  input wire [7:0] dq_out,
  input wire [18:0] fl_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence wr_pulse;
    !we_b [*3] ##1 we_b;
  endsequence
  sequence rd_pulse;
    !oe_b [*3] ##1 oe_b;
  endsequence
  wr_shape_a: assert property ($fell(we_b) |-> wr_pulse)
    else $error("write strobe width wrong");
  rd_shape_a: assert property ($fell(oe_b) |-> rd_pulse)
    else $error("read strobe width wrong");
  no_clash_a: assert property (we_b || oe_b)
    else $error("write and read strobes together");
  ce_cover_a: assert property ((!we_b || !oe_b) |-> !ce_b)
    else $error("strobe without chip enable");
  bus_turn_a: assert property (dq_oe |-> oe_b)
    else $error("data driven during a read");
  wr_hold_a: assert property (!we_b && !$past(we_b) |-> $stable(dq_out) && $stable(fl_addr) && dq_oe)
    else $error("write data or address moved");
  rd_addr_a: assert property (!oe_b && !$past(oe_b) |-> $stable(fl_addr))
    else $error("read address moved");
  idle_rst_a: assert property ($rose(rst_b) |-> ce_b && we_b && oe_b && !dq_oe)
    else $error("pins not idle after reset");
endmodule
bind flash_erase_ctl flash_erase_ctl_asserts u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .dq_oe(dq_oe), .dq_out(dq_out), .fl_addr(fl_addr));

// file: dv/flash_model.sv
module flash_model #(
  parameter int WIN = 500,
  parameter int ERS = 3000,
  parameter int SUS = 100
) (
  input wire logic clk,
  input wire logic ce_b,
  input wire logic we_b,
  input wire logic oe_b,
  input wire logic [18:0] a,
  input wire logic [7:0] d,
  output logic [7:0] q,
  output logic rb
);
  timeunit 1ns;
  timeprecision 1ns;
  // States: 0 read, 1 window, 2 erasing, 3 suspended, 4 query, 5 suspending
  int st = 0;
  int pv = 0;
  int n = 0;
  int ct = 0;
  logic [7:0] sec = 8'h00;
  logic tg = 1'b0;
  logic [7:0] v;
  logic [7:0] lv = 8'h00;
  function automatic logic ok(int i, logic [18:0] x, logic [7:0] y);
    case (i)
      0, 3: return x == 19'h00555 && y == 8'haa;
      1, 4: return x == 19'h002aa && y == 8'h55;
      2: return x == 19'h00555 && y == 8'h80;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] cfi(logic [7:0] x);
    case (x)
      8'h10: return 8'h51;
      8'h11: return 8'h52;
      8'h12: return 8'h59;
      8'h13: return 8'h02;
      8'h15: return 8'h40;
      8'h21: return 8'h0a;
      8'h27: return 8'h13;
      8'h2c: return 8'h01;
      8'h2d: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction
  // Write latched when the first of chip enable and write enable rises
  wire wr_act = !ce_b && !we_b;
  always @(negedge wr_act) begin
    if (st == 4) begin
      if (d == 8'hf0) st = pv;
    end else if (d == 8'hb0 && (st == 1 || st == 2)) begin
      st = st == 1 ? 3 : 5;
      ct = 0;
    end else if (st == 2 || st == 5) begin
      n = 0;
    end else if (d == 8'h98 && a == 19'h00055 && st != 1) begin
      pv = st;
      st = 4;
    end else if (ok(n, a, d)) begin
      n = n + 1;
    end else if (d == 8'h30 && (n == 5 || st == 1) && st != 3) begin
      if (st != 1) sec = 8'h00;
      sec[a[18:16]] = 1'b1;
      st = 1;
      ct = 0;
      n = 0;
    end else if (d == 8'h30 && st == 3 && n == 0) begin
      st = 2;
    end else begin
      n = 0;
      if (st == 1 || d == 8'hf0 && st != 3) st = 0;
    end
  end
  always @(posedge clk) begin
    ct = ct + 1;
    if (st == 1 && ct >= WIN) begin
      st = 2;
      ct = 0;
    end else if (st == 2 && ct >= ERS) st = 0;
    else if (st == 5 && ct >= SUS) st = 3;
  end
  always @(negedge oe_b) tg = ~tg;
  always @* begin
    if (st == 4) v = cfi(a[7:0]);
    else if (st == 1 || st == 2 || st == 5) v = {1'b0, tg, 2'b00, st != 1, tg, 2'b00};
    else if (st == 3 && sec[a[18:16]]) v = {3'b100, 2'b00, tg, 2'b00};
    else v = a[7:0] ^ 8'h3c;
  end
  // Released bus shows the inverse of the last value
  always @(posedge oe_b) lv = v;
  assign q = (!ce_b && !oe_b) ? v : ~lv;
  assign rb = !(st == 1 || st == 2 || st == 5);
endmodule

// file: dv/flash_erase_ctl_tb.sv
module flash_erase_ctl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string n; logic [31:0] m; logic [31:0] v;} note_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic [31:0] sw_rdata_ff;
  logic [7:0] dq_out;
  logic [7:0] mq;
  logic dq_oe, ce_b, we_b, oe_b, rb;
  logic [18:0] fl_addr;
  logic [18:0] sa, sb, sc;
  wire [7:0] dq_in = dq_oe ? dq_out : mq;
  note_t q[$];
  note_t e;
  int fails = 0;
  int checks = 0;
  int i;
  logic [7:0] offs[6] = '{8'h10, 8'h11, 8'h12, 8'h21, 8'h27, 8'h2c};
  logic [7:0] vals[6] = '{8'h51, 8'h52, 8'h59, 8'h0a, 8'h13, 8'h01};
  initial forever #50 ref_clk = ~ref_clk;
  flash_erase_ctl u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_ff(sw_rdata_ff),
    .dq_in(dq_in), .ready_busy_output(rb), .dq_out(dq_out), .dq_oe(dq_oe),
    .fl_addr(fl_addr), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b));
  flash_model u_mem (.clk(ref_clk), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b),
    .a(fl_addr), .d(dq_in), .q(mq), .rb(rb));
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] v, logic [31:0] m, string n);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    q.push_back('{n, m, v});
    @(posedge ref_clk);
    sw_rd <= 1'b0;
  endtask
  task automatic cmd(logic [2:0] c, logic [18:0] a);
    int k;
    wr(4'h1, {13'h0, a});
    wr(4'h0, {28'h0, c, 1'b1});
    for (k = 0; k < 500; k++) begin
      rd(4'h3, 32'h0, 32'h0, "busy");
      @(negedge ref_clk);
      if (sw_rdata_ff[2] === 1'b0) break;
    end
    if (k == 500) begin
      fails++;
      $display("BAD busy exp 0 got 1");
    end
  endtask
  task automatic frd(logic [18:0] a, logic [7:0] v, logic [7:0] m);
    cmd(3'h6, a);
    rd(4'h4, {24'h0, v}, {24'h0, m}, "flash byte");
  endtask
  task automatic chk(note_t x);
    checks++;
    if ((sw_rdata_ff & x.m) !== (x.v & x.m)) begin
      fails++;
      $display("BAD %s exp %h got %h", x.n, x.v & x.m, sw_rdata_ff & x.m);
    end
  endtask
  always @(posedge ref_clk) begin
    if (rd_d && q.size() > 0) begin
      e = q.pop_front();
      if (e.m !== 32'h0) chk(e);
    end
    rd_d <= sw_rd;
  end
  task complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h85f009f6));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(4'h3, 32'h0, 32'h104, "status idle");
    sa = {3'($urandom_range(7, 1)), 16'h0};
    sb = sa ^ 19'h10000;
    sc = sa ^ 19'h20000 | 19'($urandom_range(16'hffff, 0));
    cmd(3'h0, sa);
    frd(sa, 8'h00, 8'ha8);
    cmd(3'h1, sb);
    repeat (430) @(posedge ref_clk);
    frd(sa, 8'h00, 8'ha8);
    repeat (150) @(posedge ref_clk);
    frd(sa, 8'h08, 8'ha8);
    $display("end erase");
    cmd(3'h2, sa);
    frd(sa, 8'h80, 8'he0);
    frd(sc, sc[7:0] ^ 8'h3c, 8'hff);
    cmd(3'h0, sb);
    rd(4'h3, 32'h100, 32'h100, "refused erase");
    $display("end suspend");
    cmd(3'h4, 19'h00055);
    for (i = 0; i < 6; i++) frd({11'h0, offs[i]}, vals[i], 8'hff);
    cmd(3'h3, sa);
    rd(4'h3, 32'h100, 32'h100, "refused in query");
    cmd(3'h5, sa);
    frd(sa, 8'h80, 8'he0);
    $display("end query");
    cmd(3'h3, sa);
    frd(sa, 8'h08, 8'ha8);
    cmd(3'h2, sa);
    rd(4'h3, 32'h108, 32'h108, "resume gap");
    $display("end resume");
    complete_run;
  end
endmodule
